// File: core/fpcr_regs.sv
// FSK frame configuration registers with listen duty-cycle timer
//
// Summary of operation
// R1: delimiter zero: 16 bits, low/high bytes, LSB first
// R2: delimiter one: 16 bits, low/high bytes, LSB first
// R3: select bit picks delimiter for next frame
// R4: whitening bit enables payload whitening, resets on
// R5: two spare header bits copied to transmit header
// R6: snapshot refreshed on receive-frame-start event
// R7: bit 7 checksum kind, 0=32-bit, 1=16-bit
// R8: bit 6 shows received mode switch flag
// R9: bit 3 shows which delimiter was detected
// R10: bit 2 received whitening, meaningless in raw
// R11: bits 0 and 1 show spare header bits
// R12: raw length: 8 low bits plus 3 high
// R13: direct modulation needs both enable bits set
// R14: emphasis applies only with direct modulation enabled
// R15: direct modulation: FSK, or O-QPSK chip rate 0/1
// R16: bit 3 enables reduced power listen, resets 0
// R17: time unit code 0..7 doubles 0.5us..64us
// R18: active period is on count times unit
// R19: power-save period is off count times unit
// R20: two-bit frame format for second delimiter
// R21: alternate active and sleep while listening idle
`timescale 1ns/1ps
module fpcr_regs
   import fpcr_pkg::*;
#(
   parameter int BASE_UNIT_CYCLES = BASE_TIME_CYC
)
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 rx_frame_start_irq_i,
   input  wire fpcr_rx_hdr_t         rx_hdr_i,
   input  wire logic                 rx_busy_i,
   output fpcr_tx_hdr_t              tx_hdr_o,
   output logic [15:0]               delim0_o,
   output logic [15:0]               delim1_o,
   output fpcr_fmt_t                 delim1_frame_format_o,
   output logic [RAW_LEN_W-1:0]      raw_rx_len_o,
   output logic                      direct_mod_on_o,
   output logic                      emphasis_on_o,
   output logic [23:0]               emphasis_words_o,
   output logic                      listen_active_o,
   output logic                      listen_sleep_o
);

   // ----------------------------------------------------------------------
   // elaboration checks and derived widths
   // ----------------------------------------------------------------------
   localparam int MAX_UNIT = BASE_UNIT_CYCLES << (RPC_UNIT_CODES - 1);
   localparam int UNIT_W   = $clog2(MAX_UNIT + 1);

   if (BASE_UNIT_CYCLES < 1 || BASE_UNIT_CYCLES > 65536)
   begin : g_bad_unit
      $error("BASE_UNIT_CYCLES out of range");
   end

   typedef enum logic [1:0] {
      LISTEN_IDLE,
      LISTEN_ON,
      LISTEN_OFF
   } fpcr_listen_t;

   typedef struct packed {
      // software-visible registers
      logic [7:0]          delim0_lo;
      logic [7:0]          delim0_hi;
      logic [7:0]          delim1_lo;
      logic [7:0]          delim1_hi;
      logic [3:0]          tx_hdr;
      logic [7:0]          rx_snap;
      logic [7:0]          raw_lo;
      logic [RAW_HI_W-1:0] raw_hi;
      logic [1:0]          dm_ctrl;
      logic [2:0][7:0]     emph;
      logic [7:0]          tx_dfe;
      logic                rpc_en;
      logic [2:0]          rpc_time_unit;
      logic [7:0]          listen_active_units;
      logic [7:0]          listen_sleep_units;
      logic [1:0]          frame_fmt;
      logic [2:0]          phy_mode;
      // listen timer
      fpcr_listen_t        listen;
      logic [UNIT_W-1:0]   unit_cnt;
      logic [7:0]          mult_cnt;
      // bus answer and registered outputs
      logic                ack;
      logic [31:0]         rdata;
      logic                dm_active;
      logic                emph_active;
      logic                act_out;
      logic                sleep_out;
      logic [15:0]         tx_delim;
   } fpcr_state_t;

   fpcr_state_t st;
   fpcr_state_t next_st;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // true when the bus addresses the given register word
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] ofs);
      hit = (adr[7:2] == ofs[7:2]);
   endfunction

   // length of one listen time unit in clock cycles
   function automatic logic [UNIT_W-1:0] unit_len(input logic [2:0] code);
      logic [UNIT_W-1:0] base;
      base     = UNIT_W'(BASE_UNIT_CYCLES);
      unit_len = base << code;
   endfunction

   // read mux over every mapped word, zero elsewhere
   function automatic logic [31:0] read_word(input logic [7:0]  adr,
                                             input fpcr_state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (hit(adr, OFS_DELIM0_LO))  v = s.delim0_lo;
      if (hit(adr, OFS_DELIM0_HI))  v = s.delim0_hi;
      if (hit(adr, OFS_DELIM1_LO))  v = s.delim1_lo;
      if (hit(adr, OFS_DELIM1_HI))  v = s.delim1_hi;
      if (hit(adr, OFS_TX_HDR))     v = {4'h0, s.tx_hdr};
      if (hit(adr, OFS_RX_SNAP))    v = s.rx_snap;
      if (hit(adr, OFS_RAW_LEN_LO)) v = s.raw_lo;
      if (hit(adr, OFS_RAW_LEN_HI)) v = {5'h00, s.raw_hi};
      if (hit(adr, OFS_DM_CTRL))    v = {6'h00, s.dm_ctrl};
      if (hit(adr, OFS_EMPH0))      v = s.emph[0];
      if (hit(adr, OFS_EMPH1))      v = s.emph[1];
      if (hit(adr, OFS_EMPH2))      v = s.emph[2];
      if (hit(adr, OFS_TX_DFE))     v = s.tx_dfe;
      if (hit(adr, OFS_RPC_CTRL))   v = {4'h0, s.rpc_en, s.rpc_time_unit};
      if (hit(adr, OFS_LISTEN_ON))  v = s.listen_active_units;
      if (hit(adr, OFS_LISTEN_OFF)) v = s.listen_sleep_units;
      if (hit(adr, OFS_FRAME_CFG))  v = {6'h00, s.frame_fmt};
      if (hit(adr, OFS_PHY_MODE))   v = {5'h00, s.phy_mode};
      read_word = {24'h000000, v};
   endfunction

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   // write strobe, direct-mod gate and listen timer ends
   logic             wr;
   logic             dm_allowed;
   logic             on_done;
   logic             off_done;
   logic             unit_end;

   always_comb
   begin
      next_st  = st;
      // write commits at the edge where the master sees ack
      wr       = wb_cyc_i && wb_stb_i && wb_we_i && st.ack && wb_sel_i[0];

      // wishbone classic: one wait state, ack dropped after one cycle
      next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
      if (wb_cyc_i && wb_stb_i && !st.ack)
         next_st.rdata = read_word(wb_adr_i, st);

      // register writes
      if (wr)
      begin
         // delimiter pattern bytes
         if (hit(wb_adr_i, OFS_DELIM0_LO))
            next_st.delim0_lo = wb_dat_i[7:0];                // R1

         if (hit(wb_adr_i, OFS_DELIM0_HI))
            next_st.delim0_hi = wb_dat_i[7:0];                // R1

         if (hit(wb_adr_i, OFS_DELIM1_LO))
            next_st.delim1_lo = wb_dat_i[7:0];                // R2

         if (hit(wb_adr_i, OFS_DELIM1_HI))
            next_st.delim1_hi = wb_dat_i[7:0];                // R2

         // transmit header and raw length
         if (hit(wb_adr_i, OFS_TX_HDR))
            next_st.tx_hdr = wb_dat_i[3:0];                   // R3 R4 R5

         if (hit(wb_adr_i, OFS_RAW_LEN_LO))
            next_st.raw_lo = wb_dat_i[7:0];                   // R12

         if (hit(wb_adr_i, OFS_RAW_LEN_HI))
            next_st.raw_hi = wb_dat_i[RAW_HI_W-1:0];          // R12

         // direct modulation and emphasis words
         if (hit(wb_adr_i, OFS_DM_CTRL))
            next_st.dm_ctrl = wb_dat_i[1:0];

         if (hit(wb_adr_i, OFS_EMPH0))
            next_st.emph[0] = wb_dat_i[7:0];

         if (hit(wb_adr_i, OFS_EMPH1))
            next_st.emph[1] = wb_dat_i[7:0];

         if (hit(wb_adr_i, OFS_EMPH2))
            next_st.emph[2] = wb_dat_i[7:0];

         if (hit(wb_adr_i, OFS_TX_DFE))
            next_st.tx_dfe = wb_dat_i[7:0];

         // listen timer settings
         if (hit(wb_adr_i, OFS_RPC_CTRL))
         begin
            next_st.rpc_en        = wb_dat_i[RPC_EN];         // R16
            next_st.rpc_time_unit = wb_dat_i[2:0];            // R17
         end

         if (hit(wb_adr_i, OFS_LISTEN_ON))
            next_st.listen_active_units = wb_dat_i[7:0];      // R18

         if (hit(wb_adr_i, OFS_LISTEN_OFF))
            next_st.listen_sleep_units = wb_dat_i[7:0];       // R19

         // frame format and phy mode
         if (hit(wb_adr_i, OFS_FRAME_CFG))
            next_st.frame_fmt = wb_dat_i[1:0];                // R20

         if (hit(wb_adr_i, OFS_PHY_MODE))
            next_st.phy_mode = wb_dat_i[2:0];
      end

      // transmit delimiter registered from the new select and bytes
      next_st.tx_delim = next_st.tx_hdr[TXH_DELIM_SEL] ?
                         {next_st.delim1_hi, next_st.delim1_lo} :
                         {next_st.delim0_hi, next_st.delim0_lo}; // R3

      // header snapshot on frame start; reserved bits kept at zero
      if (rx_frame_start_irq_i)
      begin
         next_st.rx_snap        = rx_hdr_i;                   // R6 R7 R8
         next_st.rx_snap[5:4]   = 2'h0;                       // R9 R10 R11
      end

      // direct modulation: FSK, or O-QPSK at chip rate 0 or 1
      dm_allowed = !st.phy_mode[PHY_OQPSK]
                   || (st.phy_mode[1:0] <= 2'h1);             // R15
      next_st.dm_active = st.dm_ctrl[DM_EN] && st.tx_dfe[DFE_DM]
                          && dm_allowed;                      // R13
      next_st.emph_active = next_st.dm_active
                            && st.dm_ctrl[DM_EMPH];           // R14

      // listen duty cycle
      unit_end = (st.unit_cnt >= unit_len(st.rpc_time_unit)
                  - UNIT_W'(1));                              // R17
      on_done  = (st.mult_cnt >= st.listen_active_units);     // R18
      off_done = (st.mult_cnt >= st.listen_sleep_units);      // R19

      if (unit_end)
      begin
         next_st.unit_cnt = '0;
         next_st.mult_cnt = st.mult_cnt + 8'h01;
      end
      else
         next_st.unit_cnt = st.unit_cnt + UNIT_W'(1);

      unique case (st.listen)
         LISTEN_IDLE:
         begin
            next_st.unit_cnt = '0;
            next_st.mult_cnt = 8'h00;
            if (st.rpc_en && !rx_busy_i)
               next_st.listen = LISTEN_ON;                    // R21
         end

         LISTEN_ON:
         begin
            if (on_done && st.listen_sleep_units != 8'h00)
            begin
               next_st.listen   = LISTEN_OFF;                 // R21
               next_st.unit_cnt = '0;
               next_st.mult_cnt = 8'h00;
            end
            else if (on_done)
            begin
               next_st.unit_cnt = '0;                         // stay awake
               next_st.mult_cnt = 8'h00;
            end
         end

         LISTEN_OFF:
         begin
            if (off_done)
            begin
               next_st.listen   = LISTEN_ON;                  // R21
               next_st.unit_cnt = '0;
               next_st.mult_cnt = 8'h00;
            end
         end
      endcase

      // a disabled timer or a frame in progress keeps the receiver awake
      if (!st.rpc_en || rx_busy_i)
      begin
         next_st.listen   = LISTEN_IDLE;                      // R16
         next_st.unit_cnt = '0;
         next_st.mult_cnt = 8'h00;
      end

      next_st.act_out   = (next_st.listen != LISTEN_OFF);     // R18
      next_st.sleep_out = (next_st.listen == LISTEN_OFF);     // R19
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st                     <= '0;
         st.delim0_lo           <= RST_DELIM0_LO;
         st.delim0_hi           <= RST_DELIM0_HI;
         st.delim1_lo           <= RST_DELIM1;
         st.delim1_hi           <= RST_DELIM1;
         st.tx_hdr              <= RST_TX_HDR;                // R3 R4
         st.rx_snap             <= RST_RX_SNAP;
         st.raw_lo              <= RST_BYTE;
         st.tx_dfe              <= RST_BYTE;
         st.rpc_en              <= 1'b0;                      // R16
         st.rpc_time_unit       <= RST_RPC_UNIT;              // R17
         st.listen_active_units <= RST_BYTE;
         st.listen_sleep_units  <= RST_BYTE;
         st.frame_fmt           <= RST_FRAME_FMT;
         st.tx_delim            <= {RST_DELIM0_HI, RST_DELIM0_LO}; // R3
         // listen timer starts idle, receiver awake
         st.listen              <= LISTEN_IDLE;
         st.act_out             <= 1'b1;
      end
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------------
   // bus answer
   assign wb_ack_o   = st.ack;
   assign wb_dat_o   = st.rdata;
   // delimiters and transmit header
   assign delim0_o   = {st.delim0_hi, st.delim0_lo};          // R1
   assign delim1_o   = {st.delim1_hi, st.delim1_lo};          // R2
   assign tx_hdr_o.delim             = st.tx_delim;           // R3
   assign tx_hdr_o.delim_sel         = st.tx_hdr[TXH_DELIM_SEL];
   assign tx_hdr_o.whitening_on      = st.tx_hdr[TXH_WHITEN]; // R4
   assign tx_hdr_o.spare_hdr_bit_two = st.tx_hdr[TXH_SPARE_TWO]; // R5
   assign tx_hdr_o.spare_hdr_bit_one = st.tx_hdr[TXH_SPARE_ONE]; // R5
   // frame settings, modulation gates and listen levels
   assign delim1_frame_format_o = fpcr_fmt_t'(st.frame_fmt);  // R20
   assign raw_rx_len_o     = {st.raw_hi, st.raw_lo};          // R12
   assign direct_mod_on_o  = st.dm_active;
   assign emphasis_on_o    = st.emph_active;
   assign emphasis_words_o = st.emph;
   assign listen_active_o  = st.act_out;
   assign listen_sleep_o   = st.sleep_out;

endmodule

// File: core/fpcr_pkg.sv
// package: offsets, field layouts, reset values and types of the frame regs
package fpcr_pkg;

   // ----------------------------------------------------------------------
   // register word offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_DELIM0_LO    = 8'h00;
   localparam logic [7:0] OFS_DELIM0_HI    = 8'h04;
   localparam logic [7:0] OFS_DELIM1_LO    = 8'h08;
   localparam logic [7:0] OFS_DELIM1_HI    = 8'h0c;
   localparam logic [7:0] OFS_TX_HDR       = 8'h10;
   localparam logic [7:0] OFS_RX_SNAP      = 8'h14;
   localparam logic [7:0] OFS_RAW_LEN_LO   = 8'h18;
   localparam logic [7:0] OFS_RAW_LEN_HI   = 8'h1c;
   localparam logic [7:0] OFS_DM_CTRL      = 8'h20;
   localparam logic [7:0] OFS_EMPH0        = 8'h24;
   localparam logic [7:0] OFS_EMPH1        = 8'h28;
   localparam logic [7:0] OFS_EMPH2        = 8'h2c;
   localparam logic [7:0] OFS_TX_DFE       = 8'h30;
   localparam logic [7:0] OFS_RPC_CTRL     = 8'h34;
   localparam logic [7:0] OFS_LISTEN_ON    = 8'h38;
   localparam logic [7:0] OFS_LISTEN_OFF   = 8'h3c;
   localparam logic [7:0] OFS_FRAME_CFG    = 8'h40;
   localparam logic [7:0] OFS_PHY_MODE     = 8'h44;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_DELIM0_LO    = 8'h00;
   localparam logic [7:0] RST_DELIM0_HI    = 8'h72;
   localparam logic [7:0] RST_DELIM1       = 8'h00;
   localparam logic [3:0] RST_TX_HDR       = 4'h4;
   localparam logic [7:0] RST_RX_SNAP      = 8'h00;
   localparam logic [7:0] RST_BYTE         = 8'h00;
   localparam logic [2:0] RST_RPC_UNIT     = 3'h3;
   localparam logic [1:0] RST_FRAME_FMT    = 2'h2;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int TXH_DELIM_SEL   = 3;
   localparam int TXH_WHITEN      = 2;
   localparam int TXH_SPARE_TWO   = 1;
   localparam int TXH_SPARE_ONE   = 0;
   localparam int DM_EMPH         = 1;
   localparam int DM_EN           = 0;
   localparam int DFE_DM          = 4;
   localparam int RPC_EN          = 3;
   localparam int RAW_HI_W        = 3;
   localparam int RAW_LEN_W       = 11;
   localparam int PHY_OQPSK       = 2;

   // ----------------------------------------------------------------------
   // timing: smallest listen time unit and core clock period
   // ----------------------------------------------------------------------
   localparam int BASE_TIME_PS    = 500000;
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int BASE_TIME_CYC   = BASE_TIME_PS / CLK_PERIOD_PS;
   localparam int RPC_UNIT_CODES  = 8;

   // frame formats for the second delimiter
   typedef enum logic [1:0] {
      FPCR_FMT_UNCODED_STD = 2'h0,
      FPCR_FMT_UNCODED_RAW = 2'h1,
      FPCR_FMT_CODED_STD   = 2'h2,
      FPCR_FMT_CODED_RAW   = 2'h3
   } fpcr_fmt_t;

   // received header fields, in snapshot bit order
   typedef struct packed {
      logic       checksum_kind;
      logic       mode_switch_flag;
      logic [1:0] unused;
      logic       delim_sel;
      logic       whitening_on;
      logic       spare_hdr_bit_two;
      logic       spare_hdr_bit_one;
   } fpcr_rx_hdr_t;

   // transmit header settings for the framer
   typedef struct packed {
      logic [15:0] delim;
      logic        delim_sel;
      logic        whitening_on;
      logic        spare_hdr_bit_two;
      logic        spare_hdr_bit_one;
   } fpcr_tx_hdr_t;

endpackage

// File: tb/fpcr_regs_sva.sv
// assertion checker for the frame configuration registers
`timescale 1ns/1ps
module fpcr_regs_sva
   import fpcr_pkg::*;
#(
   parameter int BASE_UNIT_CYCLES = 2
)
(
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [7:0]   wb_adr_i,
   input wire logic [3:0]   wb_sel_i,
   input wire logic [31:0]  wb_dat_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire logic         rx_frame_start_irq_i,
   input wire fpcr_rx_hdr_t rx_hdr_i,
   input wire logic         rx_busy_i,
   input wire fpcr_tx_hdr_t tx_hdr_o,
   input wire logic [15:0]  delim0_o,
   input wire logic [15:0]  delim1_o,
   input wire logic         direct_mod_on_o,
   input wire logic         emphasis_on_o,
   input wire logic         listen_active_o,
   input wire logic         listen_sleep_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------------------------------
   // request taken and snapshot read steps
   // ----------------------------------------------------------------
   logic take_w;
   assign take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
   sequence s_snap_rd;
      rx_frame_start_irq_i ##1
      (take_w && !wb_we_i && wb_adr_i[7:2] == 6'h05);
   endsequence

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_ack_one_wait: assert property (take_w |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(take_w))
      else $error("ack without request");
   a_read_hi_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_delim0_write: assert property (take_w && wb_we_i && wb_sel_i[0] &&
      wb_adr_i[7:2] == 6'h00 |-> ##2 delim0_o[7:0] == $past(wb_dat_i[7:0], 2))
      else $error("delimiter low byte not stored");
   a_snap_capture: assert property (s_snap_rd |=>
      wb_dat_o[7:0] == (8'hcf & $past(rx_hdr_i, 2)))
      else $error("snapshot not captured");
   a_emph_needs_dm: assert property (emphasis_on_o |-> direct_mod_on_o)
      else $error("emphasis without direct modulation");
   a_listen_excl: assert property (listen_active_o != listen_sleep_o)
      else $error("listen levels not complementary");
   a_busy_awake: assert property (rx_busy_i |=> listen_active_o)
      else $error("asleep while receiving");
   a_tx_delim_pick: assert property ($stable(delim0_o) && $stable(delim1_o)
      && $stable(tx_hdr_o) |->
      tx_hdr_o.delim == (tx_hdr_o.delim_sel ? delim1_o : delim0_o))
      else $error("wrong transmit delimiter");
endmodule
bind fpcr_regs fpcr_regs_sva #(.BASE_UNIT_CYCLES(BASE_UNIT_CYCLES)) u_sva (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_frame_start_irq_i, .rx_hdr_i,
   .rx_busy_i, .tx_hdr_o, .delim0_o, .delim1_o, .direct_mod_on_o,
   .emphasis_on_o, .listen_active_o, .listen_sleep_o);

// File: tb/test_fpcr_regs.sv
// self-checking bench for the frame configuration registers
`timescale 1ns/1ps
module test_fpcr_regs
   import fpcr_pkg::*;
;
   localparam int UNIT = 2;
   typedef struct packed {logic w; logic [7:0] a, d, e;} fpcr_row_t;
   // reset reads, then write/readback rows
   localparam fpcr_row_t ROWS [21] = '{
      '{0,8'h00,0,8'h00}, '{0,8'h04,0,8'h72}, '{0,8'h08,0,8'h00},
      '{0,8'h10,0,8'h04}, '{0,8'h14,0,8'h00}, '{0,8'h34,0,8'h03},
      '{0,8'h40,0,8'h02}, '{0,8'h20,0,8'h00}, '{1,8'h00,8'ha5,8'ha5},
      '{1,8'h04,8'h3c,8'h3c}, '{1,8'h08,8'h5a,8'h5a}, '{1,8'h0c,8'hc3,8'hc3},
      '{1,8'h18,8'hff,8'hff}, '{1,8'h1c,8'h05,8'h05}, '{1,8'h24,8'h11,8'h11},
      '{1,8'h28,8'h22,8'h22}, '{1,8'h2c,8'h33,8'h33}, '{1,8'h10,8'h0f,8'h0f},
      '{1,8'h34,8'hff,8'h0f}, '{1,8'h14,8'hff,8'h00}, '{1,8'h50,8'hff,8'h00}};
   // direct modulation steps: expected {dm, emphasis}
   localparam fpcr_row_t DMR [9] = '{
      '{1,8'h20,8'h03,0}, '{1,8'h30,8'h10,3}, '{1,8'h44,8'h06,0},
      '{1,8'h44,8'h07,0}, '{1,8'h44,8'h04,3}, '{1,8'h44,8'h05,3},
      '{1,8'h20,8'h02,0}, '{1,8'h20,8'h01,2}, '{1,8'h30,8'h00,0}};
   localparam logic [7:0] SNAP [8] = '{8'h80, 8'h40, 8'h30, 8'h08,
      8'h04, 8'h02, 8'h01, 8'hff};
   logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]   wb_adr_i;
   logic [3:0]   wb_sel_i;
   logic [31:0]  wb_dat_i, wb_dat_o;
   logic         rx_frame_start_irq_i, rx_busy_i;
   fpcr_rx_hdr_t rx_hdr_i;
   fpcr_tx_hdr_t tx_hdr_o;
   logic [15:0]  delim0_o, delim1_o;
   fpcr_fmt_t    delim1_frame_format_o;
   logic [10:0]  raw_rx_len_o;
   logic [23:0]  emphasis_words_o;
   logic         direct_mod_on_o, emphasis_on_o;
   logic         listen_active_o, listen_sleep_o;
   int           errors = 0, checks_done = 0, cycles = 0, on_n, off_n, s;

   fpcr_regs #(.BASE_UNIT_CYCLES(UNIT)) dut_u (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .rx_frame_start_irq_i, .rx_hdr_i, .rx_busy_i, .tx_hdr_o,
      .delim0_o, .delim1_o, .delim1_frame_format_o, .raw_rx_len_o,
      .direct_mod_on_o, .emphasis_on_o, .emphasis_words_o,
      .listen_active_o, .listen_sleep_o);

   // clock and cycle ceiling
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, d,
                     output logic [7:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      cmp(q, e);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk_i);
   endtask
   // one full awake and sleep period after the current one ends
   task automatic measure;
      while (listen_sleep_o !== 1'b1) @(posedge clk_i);
      while (listen_sleep_o === 1'b1) @(posedge clk_i);
      on_n = 0;
      off_n = 0;
      while (listen_active_o === 1'b1) begin @(posedge clk_i); on_n++; end
      while (listen_sleep_o === 1'b1) begin @(posedge clk_i); off_n++; end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, rx_frame_start_irq_i, rx_busy_i} = '0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h0;
      rx_hdr_i = '0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      cmp(delim0_o, 16'h7200);
      cmp({tx_hdr_o.delim_sel, tx_hdr_o.whitening_on}, 2'b01);
      cmp({listen_active_o, listen_sleep_o}, 2'b10);
      @(posedge clk_i);
      for (int i = 0; i < 21; i++)
      begin
         if (ROWS[i].w)
            wr(ROWS[i].a, ROWS[i].d);
         rd_chk(ROWS[i].a, ROWS[i].e);
      end
      settle();
      cmp(delim1_o, 16'hc35a);
      cmp(tx_hdr_o, {16'hc35a, 4'hf});
      cmp(raw_rx_len_o, 11'h5ff);
      cmp(emphasis_words_o, 24'h332211);
      wr(8'h10, 8'h02);
      settle();
      cmp(tx_hdr_o, {16'h3ca5, 4'h2});
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h40, 8'(c));
         settle();
         cmp(delim1_frame_format_o, 24'(c));
      end
      foreach (DMR[i])
      begin
         wr(DMR[i].a, DMR[i].d);
         settle();
         cmp({direct_mod_on_o, emphasis_on_o}, DMR[i].e);
      end
      // capture, then scramble the header so a late copy shows up
      foreach (SNAP[i])
      begin
         rx_hdr_i <= SNAP[i];
         rx_frame_start_irq_i <= 1'b1;
         @(posedge clk_i);
         rx_frame_start_irq_i <= 1'b0;
         rx_hdr_i <= ~SNAP[i];
         rd_chk(8'h14, SNAP[i] & 8'hcf);
      end
      rd_chk(8'h14, 8'hcf);
      wr(8'h38, 8'h02);
      wr(8'h3c, 8'h03);
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h34, 8'h08 | 8'(c));
         measure();
         cmp(24'(on_n), 24'(2 * (UNIT << c) + 1));
         cmp(24'(off_n), 24'(3 * (UNIT << c) + 1));
      end
      rx_busy_i <= 1'b1;
      s = 0;
      repeat (60) begin @(posedge clk_i); s += int'(listen_active_o !== 1'b1); end
      cmp(24'(s), 24'h0);
      rx_busy_i <= 1'b0;
      measure();
      cmp(24'(off_n), 24'(3 * (UNIT << 2) + 1));
      // disable while asleep so the wake-up is seen
      while (listen_sleep_o !== 1'b1) @(posedge clk_i);
      wr(8'h34, 8'h02);
      settle();
      cmp({listen_active_o, listen_sleep_o}, 2'b10);
      // mid-run reset restores the defaults
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      cmp(delim0_o, 16'h7200);
      rd_chk(8'h10, 8'h04);
      rd_chk(8'h14, 8'h00);
      rd_chk(8'h34, 8'h03);
      finish_test();
   end
endmodule
